// ===== dvrc_pkg.sv
// constants for the right-channel volume ramp controller
// assumes a host register port with address, write strobe and read data
package dvrc_pkg;
    localparam logic [7:0] ADDR_RIGHT_VOLUME     = 8'h3e;
    localparam logic [7:0] ADDR_NORMAL_RAMP      = 8'h3f;
    localparam logic [7:0] ADDR_EMERGENCY_RAMP   = 8'h40;
    localparam logic [7:0] RIGHT_VOLUME_RESET    = 8'h30;
    localparam logic [7:0] NORMAL_RAMP_RESET     = 8'h11;
    localparam logic [7:0] EMERGENCY_RAMP_RESET  = 8'h10;
    localparam logic [7:0] UNITY_CODE            = 8'h30;
    localparam logic [7:0] MUTE_CODE             = 8'hff;
    localparam logic [1:0] LINK_FOLLOW_LEFT      = 2'h1;
    localparam logic [1:0] RATE_INSTANT          = 2'h3;
    localparam int         NDOWN_RATE_POS        = 6;
    localparam int         NDOWN_STEP_POS        = 4;
    localparam int         NUP_RATE_POS          = 2;
    localparam int         NUP_STEP_POS          = 0;
    localparam int         EDOWN_RATE_POS        = 6;
    localparam int         EDOWN_STEP_POS        = 4;
    typedef enum logic [1:0] {
        DVRC_IDLE = 2'b00,
        DVRC_DOWN = 2'b01,
        DVRC_EDOWN = 2'b10,
        DVRC_UP = 2'b11
    } dvrc_state_t;
endpackage : dvrc_pkg

// ===== dvrc_volume_ramp.sv
// right-channel digital volume ramp controller
// holds the right volume code and the two ramp control registers, and
// steps the applied volume code toward its target, one step per update
// assumes clk is the device clock; sample_tick pulses once per sample period
// assumes register inputs, mute requests and link inputs are synchronous to clk
// a larger code means less gain; code ff is full mute
`timescale 1ns/1ps
`default_nettype none
module dvrc_volume_ramp (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic [7:0] reg_addr,
    input  wire logic       reg_write,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    input  wire logic       sample_tick,
    input  wire logic       soft_mute_pin_n,
    input  wire logic       soft_mute_reg,
    input  wire logic       clock_error,
    input  wire logic       power_loss,
    input  wire logic [1:0] volume_link_mode,
    input  wire logic [7:0] left_volume_code,
    output logic      [7:0] applied_volume,
    output logic            ramp_busy
);
    logic [7:0] right_volume_code;
    logic [7:0] normal_ramp_control;
    logic [7:0] emergency_ramp_control;
    logic [1:0] tick_count;
    dvrc_pkg::dvrc_state_t state;
    dvrc_pkg::dvrc_state_t next_state;

    // step sizes in half-dB code units
    // 00 is 4 dB, 01 is 2 dB, 10 is 1 dB, 11 is 0.5 dB
    // shared by the down, up and emergency step fields
    function automatic logic [7:0] step_units(input logic [1:0] sel);
        case (sel)
            2'h0: step_units = 8'h08;
            2'h1: step_units = 8'h04;
            2'h2: step_units = 8'h02;
            default: step_units = 8'h01;
        endcase
    endfunction : step_units

    // update interval in sample periods minus one
    // 00 every period, 01 every second, 10 every fourth
    // 11 is the instant jump and never waits on the counter
    function automatic logic [1:0] rate_last(input logic [1:0] sel);
        case (sel)
            2'h0: rate_last = 2'h0;
            2'h1: rate_last = 2'h1;
            default: rate_last = 2'h3;
        endcase
    endfunction : rate_last

    // field selection
    wire [1:0] normal_down_rate    = normal_ramp_control[dvrc_pkg::NDOWN_RATE_POS +: 2];
    wire [1:0] normal_down_step    = normal_ramp_control[dvrc_pkg::NDOWN_STEP_POS +: 2];
    wire [1:0] normal_up_rate      = normal_ramp_control[dvrc_pkg::NUP_RATE_POS +: 2];
    wire [1:0] normal_up_step      = normal_ramp_control[dvrc_pkg::NUP_STEP_POS +: 2];
    wire [1:0] emergency_down_rate = emergency_ramp_control[dvrc_pkg::EDOWN_RATE_POS +: 2];
    wire [1:0] emergency_down_step = emergency_ramp_control[dvrc_pkg::EDOWN_STEP_POS +: 2];

    // mute requests and effective target
    // emergency wins over soft mute so a failing clock or supply
    // always gets the emergency settings, which reset to the same rate and step as the normal down settings
    wire emergency = clock_error | power_loss;
    wire soft_mute = ~soft_mute_pin_n | soft_mute_reg;
    wire [7:0] gain_code = (volume_link_mode == dvrc_pkg::LINK_FOLLOW_LEFT)
                         ? left_volume_code : right_volume_code;
    // larger code is less gain; ff is mute so ramp there ends at mute
    wire [7:0] target = (emergency | soft_mute) ? dvrc_pkg::MUTE_CODE : gain_code;

    // ramp direction and active settings
    // a larger code is quieter, so ramping down means counting up;
    // the mode is picked from where the target lies right now, so a
    // target moved mid-ramp turns the ramp around in one cycle
    wire going_down = target > applied_volume;
    wire going_up   = target < applied_volume;
    always_comb begin
        if (emergency && going_down)
            next_state = dvrc_pkg::DVRC_EDOWN;
        else if (going_down)
            next_state = dvrc_pkg::DVRC_DOWN;
        else if (going_up)
            next_state = dvrc_pkg::DVRC_UP;
        else
            next_state = dvrc_pkg::DVRC_IDLE;
    end

    // rate and step fields of the mode that is about to run
    // idle selects harmless values; nothing is applied then
    logic [1:0] sel_rate;
    logic [1:0] sel_step;
    always_comb begin
        case (next_state)
            dvrc_pkg::DVRC_EDOWN: begin
                sel_rate = emergency_down_rate;
                sel_step = emergency_down_step;
            end
            dvrc_pkg::DVRC_DOWN: begin
                sel_rate = normal_down_rate;
                sel_step = normal_down_step;
            end
            dvrc_pkg::DVRC_UP: begin
                sel_rate = normal_up_rate;
                sel_step = normal_up_step;
            end
            default: begin
                sel_rate = 2'h0;
                sel_step = 2'h0;
            end
        endcase
    end

    // one step toward target, clamped so it never overshoots
    // the clamp also keeps the sum from wrapping past ff
    // a change of mode gives no update in that cycle unless the rate is instant, so the new
    // interval always starts from a cleared counter
    wire       fresh    = next_state != state;
    wire [7:0] step     = step_units(sel_step);
    wire [7:0] distance = going_down ? (target - applied_volume) : (applied_volume - target);
    wire       clamp    = step >= distance;
    wire [7:0] stepped  = going_down ? (applied_volume + step) : (applied_volume - step);
    wire       instant  = sel_rate == dvrc_pkg::RATE_INSTANT;
    wire       update   = sample_tick && !fresh && (tick_count >= rate_last(sel_rate));
    wire [7:0] next_applied = (instant || clamp) ? target : stepped;

    // register reads, unmapped offsets read zero
    // combinational, so data follows the address in the same cycle
    always_comb begin
        case (reg_addr)
            dvrc_pkg::ADDR_RIGHT_VOLUME:   reg_rdata = right_volume_code;
            dvrc_pkg::ADDR_NORMAL_RAMP:    reg_rdata = normal_ramp_control;
            dvrc_pkg::ADDR_EMERGENCY_RAMP: reg_rdata = emergency_ramp_control;
            default:                       reg_rdata = 8'h00;
        endcase
    end

    // write strobes, one per mapped offset; other offsets are ignored
    wire write_volume    = reg_write && (reg_addr == dvrc_pkg::ADDR_RIGHT_VOLUME);
    wire write_normal    = reg_write && (reg_addr == dvrc_pkg::ADDR_NORMAL_RAMP);
    wire write_emergency = reg_write && (reg_addr == dvrc_pkg::ADDR_EMERGENCY_RAMP);

    // right volume code register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            right_volume_code <= dvrc_pkg::RIGHT_VOLUME_RESET;
        else if (write_volume)
            right_volume_code <= reg_wdata;
    end

    // soft mute and unmute ramp settings
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            normal_ramp_control <= dvrc_pkg::NORMAL_RAMP_RESET;
        else if (write_normal)
            normal_ramp_control <= reg_wdata;
    end

    // emergency ramp settings; low nibble is stored but unused
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            emergency_ramp_control <= dvrc_pkg::EMERGENCY_RAMP_RESET;
        else if (write_emergency)
            emergency_ramp_control <= reg_wdata;
    end

    // ramp mode register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            state <= dvrc_pkg::DVRC_IDLE;
        else
            state <= next_state;
    end

    // interval counter, restarted on any change of ramp mode
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            tick_count <= 2'h0;
        else if (next_state == dvrc_pkg::DVRC_IDLE || fresh)
            tick_count <= 2'h0;
        else if (instant || update)
            tick_count <= 2'h0;
        else if (sample_tick)
            tick_count <= tick_count + 2'h1;
    end

    // applied code: one clamped step per update, or a jump when instant
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            applied_volume <= dvrc_pkg::UNITY_CODE;
        else if (next_state != dvrc_pkg::DVRC_IDLE && (instant || update))
            applied_volume <= next_applied;
    end

    // busy follows the registered mode, so it lags the request by a cycle
    // and drops in the cycle after the target is reached
    assign ramp_busy = state != dvrc_pkg::DVRC_IDLE;

    // limitations: the left channel, auto mute and analog mute delay
    // live elsewhere; left_volume_code is taken as already synchronous;
    // a mute request shorter than one update interval may leave the
    // applied code part way down before the ramp turns back up
endmodule : dvrc_volume_ramp
`default_nettype wire

// ===== dvrc_host_model.sv
// host side model: sample tick source and soft mute pin driver
// assumes one clock; changes its outputs just after the rising edge
`timescale 1ns/1ps
`default_nettype none
module dvrc_host_model #(parameter int TICK = 3) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic mute_req,
    output logic      sample_tick,
    output logic      soft_mute_pin_n
);
    int cnt;
    // one tick every TICK clocks, pin low while mute is asked for
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 0;
            sample_tick <= 1'b0;
            soft_mute_pin_n <= 1'b1;
        end else begin
            cnt <= (cnt + 1) % TICK;
            sample_tick <= (cnt == 0);
            soft_mute_pin_n <= !mute_req;
        end
    end
endmodule : dvrc_host_model
`default_nettype wire

// ===== dvrc_volume_ramp_props.sv
// assertions on the volume ramp ports
// assumes bind to dvrc_volume_ramp
`timescale 1ns/1ps
`default_nettype none
module dvrc_ramp_chk (
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic       reg_write,
    input wire logic       sample_tick,
    input wire logic       soft_mute_pin_n,
    input wire logic       soft_mute_reg,
    input wire logic       clock_error,
    input wire logic       power_loss,
    input wire logic       ramp_busy,
    input wire logic [1:0] volume_link_mode,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic [7:0] left_volume_code,
    input wire logic [7:0] applied_volume
);
    // any mute request, soft or emergency
    wire logic       mute_on = !soft_mute_pin_n || soft_mute_reg || clock_error || power_loss;
    wire logic [7:0] av = applied_volume;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    chk_reset_unity: assert property (!$past(rst_n) |-> av == 8'h30)
        else $error("volume not unity after reset");
    chk_reset_ramp: assert property (!$past(rst_n) && reg_addr == 8'h3f |-> reg_rdata == 8'h11)
        else $error("ramp settings wrong after reset");
    chk_unmapped_zero: assert property (!(reg_addr inside {8'h3e, 8'h3f, 8'h40}) |-> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    chk_write_back: assert property (reg_write && reg_addr inside {8'h3e, 8'h3f, 8'h40}
        |=> !$stable(reg_addr) || reg_rdata == $past(reg_wdata)) else $error("write not read back");
    chk_mute_dir: assert property (mute_on && $past(mute_on) && $changed(av) |-> av > $past(av))
        else $error("volume rose while muting");
    chk_step_bound: assert property (mute_on && $past(mute_on) && $changed(av) && av != 8'hff
        |-> av - $past(av) <= 8'h08) else $error("down step too large");
    chk_down_tick: assert property (mute_on && $past(mute_on) && $changed(av) && av != 8'hff
        |-> $past(sample_tick)) else $error("down step without tick");
    chk_mute_hold: assert property (mute_on && $past(mute_on) && $past(av) == 8'hff |-> av == 8'hff)
        else $error("mute level left while muted");
    cover property (av == 8'hff && clock_error);
    cover property (volume_link_mode == 2'h1 && av == left_volume_code);
    cover property (soft_mute_reg && $changed(av));
endmodule : dvrc_ramp_chk
bind dvrc_volume_ramp dvrc_ramp_chk u_chk (.clk, .rst_n, .reg_write, .sample_tick, .soft_mute_pin_n,
    .soft_mute_reg, .clock_error, .power_loss, .ramp_busy, .volume_link_mode, .reg_addr, .reg_wdata,
    .reg_rdata, .left_volume_code, .applied_volume);
`default_nettype wire

// ===== digital_volume_ramp_control_bench.sv
// self-checking bench for the volume ramp controller
// assumes the host model supplies tick and pin
`timescale 1ns/1ps
`default_nettype none
module digital_volume_ramp_control_bench;
    logic       clk = 0, rst_n = 0, reg_write = 0, soft_mute_reg = 0, clock_error = 0, power_loss = 0;
    logic       mute_req = 0, sel;
    logic [1:0] volume_link_mode = 2'h0;
    logic [7:0] reg_addr = 8'h3f, reg_wdata = 8'h00, left_volume_code = 8'h40, e, g, d, stp, q[$];
    wire logic [7:0] reg_rdata, applied_volume;
    wire logic  sample_tick, soft_mute_pin_n, ramp_busy;
    int         err_count, compares, seed = 32'ha106, i;
    event       probe;
    always #2.5 clk = !clk;
    dvrc_volume_ramp dut (.clk, .rst_n, .reg_addr, .reg_write, .reg_wdata, .reg_rdata, .sample_tick,
        .soft_mute_pin_n, .soft_mute_reg, .clock_error, .power_loss, .volume_link_mode,
        .left_volume_code, .applied_volume, .ramp_busy);
    dvrc_host_model host (.clk, .rst_n, .mute_req, .sample_tick, .soft_mute_pin_n);
    // watcher: oldest note against the selected output
    always @(probe) begin
        e = q.pop_front();
        g = sel ? reg_rdata : applied_volume;
        compares++;
        if (g !== e) begin
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
            err_count++;
        end
    end
    task automatic chk(input logic s, input logic [7:0] x);
        sel = s;
        q.push_back(x);
        ->probe;
        @(negedge clk);
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        reg_addr = a;
        reg_wdata = v;
        reg_write = 1'b1;
        @(negedge clk) reg_write = 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] x);
        reg_addr = a;
        #1 chk(1'b1, x);
    endtask : rd
    // wait for the next volume change, counting ticks since the last one
    task automatic nxt(input logic [7:0] x, input int r);
        int n = 0;
        int k = 0;
        logic [7:0] v = applied_volume;
        while (applied_volume === v && k < 300) begin
            @(posedge clk) n += sample_tick;
            @(negedge clk) k++;
        end
        if (k == 300) begin
            $display("[FAIL] %0t timeout got %h exp %h", $time, applied_volume, x);
            err_count++;
            wrap_up();
        end
        chk(1'b0, x);
        if (r > 0 && n != r) begin
            $display("[FAIL] %0t ticks %h exp %h", $time, n, r);
            err_count++;
        end
    endtask : nxt
    task automatic wrap_up;
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : wrap_up
    initial begin
        repeat (16) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        rd(8'h3f, 8'h11);
        rd(8'h40, 8'h10);
        rd(8'h3e, 8'h30);
        chk(1'b0, 8'h30);
        repeat (4) begin
            d = $random(seed);
            wr(8'h40, d);
            rd(8'h40, d);
            wr({1'b1, d[6:0]}, d);
            rd({1'b1, d[6:0]}, 8'h00);
        end
        $display("register test done");
        // every rate and step code, soft then emergency mute
        for (i = 0; i < 4; i++) begin
            stp = 8'h08 >> i;
            wr(8'h3f, {i[1:0], i[1:0], 2'h3, i[1:0]});
            wr(8'h40, {2'(3 - i), i[1:0], 4'h0});
            if (i[0]) mute_req = 1'b1;
            else soft_mute_reg = 1'b1;
            if (i < 3) nxt(8'h30 + stp, 0);
            if (i < 3) nxt(8'h30 + stp + stp, 1 << i);
            else nxt(8'hff, 0);
            mute_req = 1'b0;
            soft_mute_reg = 1'b0;
            nxt(8'h30, 0);
            if (i[1]) power_loss = 1'b1;
            else clock_error = 1'b1;
            if (i > 0) nxt(8'h30 + stp, 0);
            if (i > 0) nxt(8'h30 + stp + stp, 1 << (3 - i));
            else nxt(8'hff, 0);
            clock_error = 1'b0;
            power_loss = 1'b0;
            nxt(8'h30, 0);
            $display("mute code set %0d done", i);
        end
        // ramp up with a clamped last step, then follow the left code
        wr(8'h3f, 8'h00);
        wr(8'h3e, 8'h26);
        nxt(8'h28, 0);
        nxt(8'h26, 1);
        volume_link_mode = 2'h1;
        nxt(8'h2e, 0);
        nxt(8'h36, 1);
        nxt(8'h3e, 1);
        nxt(8'h40, 1);
        $display("ramp and link done");
        wrap_up();
    end
endmodule : digital_volume_ramp_control_bench
`default_nettype wire
